// [logic/sweep_trigger_ctrl.sv]
`timescale 1ns/1ps
`include "sweep_trig_cfg.svh"

// How it works
// - request recalibration when frequency move exceeds 33-bit step limit while sweep enable is set
// - fast reuse seeds calibration from last core, capcode and bias
// - starting capcode seeds calibration when its use bit is set and fast reuse is not seeding from last, kept below 184
// - sweep limits, triggers and burst act only while sweep enable is set
// - hold sweep when position reaches 33-bit upper bound
// - hold sweep when position reaches 33-bit lower bound
// - burst runs exactly the programmed sweeps from enable rising, then stops
// - completed sweeps are counted against the burst length field
// - segment-0 accumulator cleared at each sweep start, automatic mode only
// - trigger A decodes off, pin rises, always, pin falls
// - trigger B uses same decoding from its own field
// - burst advances on transition, trigger A or trigger B; 3 never
// - manual select bit chooses manual sweeping, else automatic
module sweep_trigger_ctrl (
  // clock and reset
  input  wire logic                     mclk,
  input  wire logic                     reset_n,
  // register bus
  input  wire sweep_trig_pkg::axi_req_s axi_req,
  output sweep_trig_pkg::axi_rsp_s      axi_rsp,
  // trigger pins
  input  wire logic                     sweep_clock_pin,
  input  wire logic                     sweep_direction_pin,
  // sweep engine
  input  wire logic                     sweep_step,
  input  wire logic [32:0]              sweep_pos,
  input  wire logic [32:0]              freq_move,
  input  wire logic                     cal_done,
  input  wire sweep_trig_pkg::seed_s    last_seed,
  // sweep engine controls
  output logic                          sweep_run,
  output logic                          manual_mode,
  output logic                          trig_a,
  output logic                          trig_b,
  output logic                          burst_step,
  output logic                          seg0_clear,
  output logic                          hold_high,
  output logic                          hold_low,
  output logic                          recal_req,
  output sweep_trig_pkg::seed_s         seed,
  output logic                          seed_from_last
);

  typedef struct packed {
    sweep_trig_pkg::axi_rsp_s rsp;
    logic                     aw_got;
    logic                     w_got;
    logic [11:0]              awaddr;
    logic [15:0]              wdata;
    logic [1:0]               wstrb;
    logic [11:0][15:0]        regs;
    logic [1:0]               pin_s1;
    logic [1:0]               pin_s2;
    logic [1:0]               pin_d;
    logic                     en_d;
    sweep_trig_pkg::burst_e   burst;
    logic [12:0]              done_cnt;
    logic                     have_last;
    sweep_trig_pkg::seed_s    last;
    logic                     run;
    logic                     ta;
    logic                     tb;
    logic                     bstep;
    logic                     clr;
    logic                     hi;
    logic                     lo;
    logic                     recal;
    sweep_trig_pkg::seed_s    seed;
    logic                     from_last;
  } state_s;

  state_s s;
  state_s next_s;

  // ************************************************
  // decode helpers
  // ************************************************
  function automatic logic [3:0] slot_of(input logic [11:0] addr);
    case (addr[8:2])
      `IDX_RECAL_CTRL:  slot_of = 4'h0;
      `IDX_LIMIT_UPPER: slot_of = 4'h1;
      `IDX_LIMIT_LOWER: slot_of = 4'h2;
      `IDX_UB_MSB:      slot_of = 4'h3;
      `IDX_UB_MID:      slot_of = 4'h4;
      `IDX_UB_LOW:      slot_of = 4'h5;
      `IDX_LB_MSB:      slot_of = 4'h6;
      `IDX_LB_MID:      slot_of = 4'h7;
      `IDX_LB_LOW:      slot_of = 4'h8;
      `IDX_BURST:       slot_of = 4'h9;
      `IDX_TRIGGER:     slot_of = 4'ha;
      `IDX_SWEEP_CTRL:  slot_of = 4'hb;
      `IDX_SWEEP_STAT:  slot_of = 4'hc;
      default:          slot_of = 4'hf;
    endcase
    if (addr[11:9] != 3'h0 || addr[1:0] != 2'h0) begin
      slot_of = 4'hf;
    end
  endfunction

  function automatic logic [15:0] wmask(input logic [3:0] sl);
    case (sl)
      4'h0:        wmask = `MASK_RECAL_CTRL;
      4'h3, 4'h6:  wmask = `MASK_BIT0;
      4'h9:        wmask = `MASK_BURST;
      4'ha:        wmask = `MASK_TRIGGER;
      4'hb:        wmask = `MASK_CTRL;
      4'hc, 4'hf:  wmask = 16'h0000;
      default:     wmask = `MASK_FULL;
    endcase
  endfunction

  // reserved and disabled codes both land here, so nothing fires spuriously
  function automatic logic trig_hit(input logic [3:0] code, input logic [1:0] rise,
                                    input logic [1:0] fall);
    case (code)
      `TRG_CLK_RISE: trig_hit = rise[1];
      `TRG_DIR_RISE: trig_hit = rise[0];
      `TRG_ALWAYS:   trig_hit = 1'b1;
      `TRG_CLK_FALL: trig_hit = fall[1];
      `TRG_DIR_FALL: trig_hit = fall[0];
      default:       trig_hit = 1'b0;
    endcase
  endfunction

  // ************************************************
  // register fields
  // ************************************************
  logic        en;
  logic        man;
  logic        cap_use;
  logic        fast;
  logic [7:0]  start_cap;
  logic [32:0] step_limit;
  logic [32:0] upper;
  logic [32:0] lower;
  logic        burst_en;
  logic [12:0] burst_len;
  logic        clr_en;
  logic [3:0]  code_a;
  logic [3:0]  code_b;
  logic [1:0]  step_src;
  logic [1:0]  rise;
  logic [1:0]  fall;
  logic        en_rise;
  logic        ta;
  logic        tb;
  logic        step;
  logic [15:0] status;

  assign en         = s.regs[11][`CT_SWEEP_EN];
  assign man        = s.regs[11][`CT_MANUAL];
  assign cap_use    = s.regs[11][`CT_CAP_USE];
  assign fast       = s.regs[0][`RC_FAST_REUSE];
  assign start_cap  = s.regs[0][`RC_CAP_LO +: 8];
  assign step_limit = {s.regs[0][`RC_LIMIT_MSB], s.regs[1], s.regs[2]};
  assign upper      = {s.regs[3][0], s.regs[4], s.regs[5]};
  assign lower      = {s.regs[6][0], s.regs[7], s.regs[8]};
  assign burst_en   = s.regs[9][`BU_ENABLE];
  assign burst_len  = s.regs[9][`BU_COUNT_LO +: 13];
  assign clr_en     = s.regs[10][`TR_SEG0_CLEAR] && !man;
  assign code_a     = s.regs[10][`TR_A_LO +: 4];
  assign code_b     = s.regs[10][`TR_B_LO +: 4];
  assign step_src   = s.regs[10][`TR_STEP_LO +: 2];
  // edges seen only from the second sync stage onward
  assign rise       = s.pin_s2 & ~s.pin_d;
  assign fall       = ~s.pin_s2 & s.pin_d;
  assign en_rise    = en && !s.en_d;
  assign ta         = en && trig_hit(code_a, rise, fall);
  assign tb         = en && trig_hit(code_b, rise, fall);
  assign status     = {s.recal, s.burst == sweep_trig_pkg::BURST_DONE,
                       s.burst == sweep_trig_pkg::BURST_RUN, s.done_cnt};

  always_comb begin
    case (step_src)
      `STEP_TRANSITION: step = sweep_step;
      `STEP_TRIG_A:     step = ta;
      `STEP_TRIG_B:     step = tb;
      default:          step = 1'b0;
    endcase
  end

  // ************************************************
  // next state
  // ************************************************
  always_comb begin
    logic [3:0] wsl;
    logic [3:0] rsl;
    logic [15:0] wm;
    logic [15:0] rv;
    wsl = slot_of(s.awaddr);
    rsl = slot_of(axi_req.araddr);
    wm = wmask(wsl) & {{8{s.wstrb[1]}}, {8{s.wstrb[0]}}};
    rv = 16'h0000;
    next_s = s;

    // write channels are taken in either order, answered once both are in
    if (axi_req.awvalid && s.rsp.awready) begin
      next_s.aw_got = 1'b1;
      next_s.awaddr = axi_req.awaddr;
      next_s.rsp.awready = 1'b0;
    end
    if (axi_req.wvalid && s.rsp.wready) begin
      next_s.w_got = 1'b1;
      next_s.wdata = axi_req.wdata[15:0];
      next_s.wstrb = axi_req.wstrb[1:0];
      next_s.rsp.wready = 1'b0;
    end
    if (s.aw_got && s.w_got && !s.rsp.bvalid) begin
      if (wsl < 4'hc) begin
        next_s.regs[wsl] = (s.regs[wsl] & ~wm) | (s.wdata & wm);
      end
      next_s.rsp.bvalid = 1'b1;
      next_s.rsp.bresp = (wsl == 4'hf) ? `RESP_SLVERR : `RESP_OKAY;
    end
    if (s.rsp.bvalid && axi_req.bready) begin
      next_s.rsp.bvalid = 1'b0;
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.rsp.awready = 1'b1;
      next_s.rsp.wready = 1'b1;
    end

    if (axi_req.arvalid && s.rsp.arready) begin
      if (rsl == 4'hc) begin
        rv = status;
      end else if (rsl < 4'hc) begin
        rv = s.regs[rsl] & wmask(rsl);
      end
      if (rsl == 4'h0) begin
        rv = rv | `ONES_RECAL_CTRL;
      end
      if (rsl == 4'ha) begin
        rv = rv | `ONES_TRIGGER;
      end
      next_s.rsp.rdata = {16'h0000, rv};
      next_s.rsp.rresp = (rsl == 4'hf) ? `RESP_SLVERR : `RESP_OKAY;
      next_s.rsp.rvalid = 1'b1;
      next_s.rsp.arready = 1'b0;
    end else if (s.rsp.rvalid && axi_req.rready) begin
      next_s.rsp.rvalid = 1'b0;
      next_s.rsp.arready = 1'b1;
    end

    next_s.pin_s1 = {sweep_clock_pin, sweep_direction_pin};
    next_s.pin_s2 = s.pin_s1;
    next_s.pin_d = s.pin_s2;
    next_s.en_d = en;
    next_s.ta = ta;
    next_s.tb = tb;
    next_s.clr = 1'b0;
    next_s.bstep = 1'b0;

    // a sweep that starts without burst: enable rising or segment turn
    if (!burst_en && en && (en_rise || sweep_step)) begin
      next_s.clr = clr_en;
    end

    case (s.burst)
      sweep_trig_pkg::BURST_IDLE: begin
        if (en_rise && burst_en) begin
          next_s.done_cnt = 13'h0000;
          if (burst_len == 13'h0000) begin
            next_s.burst = sweep_trig_pkg::BURST_DONE;
          end else begin
            next_s.burst = sweep_trig_pkg::BURST_RUN;
            next_s.clr = clr_en;
          end
        end
      end
      sweep_trig_pkg::BURST_RUN: begin
        if (!en) begin
          next_s.burst = sweep_trig_pkg::BURST_IDLE;
        end else if (step) begin
          next_s.bstep = 1'b1;
          next_s.done_cnt = s.done_cnt + 13'h0001;
          if (s.done_cnt + 13'h0001 >= burst_len) begin
            next_s.burst = sweep_trig_pkg::BURST_DONE;
          end else begin
            next_s.clr = clr_en;
          end
        end
      end
      sweep_trig_pkg::BURST_DONE: begin
        if (!en) begin
          next_s.burst = sweep_trig_pkg::BURST_IDLE;
        end
      end
      default: begin
        next_s.burst = sweep_trig_pkg::BURST_IDLE;
      end
    endcase

    next_s.run = en && (!burst_en || next_s.burst == sweep_trig_pkg::BURST_RUN);
    next_s.hi = en && ($signed(sweep_pos) >= $signed(upper));
    next_s.lo = en && ($signed(sweep_pos) <= $signed(lower));
    next_s.recal = en && (freq_move > step_limit);

    if (cal_done) begin
      next_s.last = last_seed;
      next_s.have_last = 1'b1;
    end
    // reuse needs one finished calibration; until then seed from defaults
    if (fast && s.have_last) begin
      next_s.seed = s.last;
      next_s.from_last = 1'b1;
    end else begin
      next_s.seed = '0;
      next_s.from_last = 1'b0;
      if (cap_use) begin
        next_s.seed.capcode = (start_cap > `CAPCODE_MAX) ? `CAPCODE_MAX : start_cap;
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
      s.rsp.awready <= 1'b1;
      s.rsp.wready <= 1'b1;
      s.rsp.arready <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ************************************************
  // outputs
  // ************************************************
  assign axi_rsp        = s.rsp;
  assign sweep_run      = s.run;
  assign manual_mode    = man;
  assign trig_a         = s.ta;
  assign trig_b         = s.tb;
  assign burst_step     = s.bstep;
  assign seg0_clear     = s.clr;
  assign hold_high      = s.hi;
  assign hold_low       = s.lo;
  assign recal_req      = s.recal;
  assign seed           = s.seed;
  assign seed_from_last = s.from_last;

  // ************************************************
  // assertions
  // ************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence burst_arm;
    en_rise && burst_en && burst_len != 13'h0000 && s.burst == sweep_trig_pkg::BURST_IDLE;
  endsequence

  sequence clk_rise_a;
    (en && code_a == `TRG_CLK_RISE && $rose(sweep_clock_pin))
      ##1 (en && code_a == `TRG_CLK_RISE) [*2];
  endsequence

  a_recal_request: assert property (en && freq_move > step_limit |=> recal_req)
    else $error("recal request missing");
  a_seed_reuse: assert property (fast && s.have_last
      |=> seed_from_last && seed == $past(s.last))
    else $error("seed not taken from last calibration");
  a_cap_range: assert property (!seed_from_last |-> seed.capcode <= `CAPCODE_MAX)
    else $error("start capcode out of range");
  a_off_quiet: assert property (!en |=> !trig_a && !trig_b && !hold_high && !hold_low
      && !burst_step && !sweep_run)
    else $error("sweep output active while disabled");
  a_hold_upper: assert property (en && $signed(sweep_pos) >= $signed(upper) |=> hold_high)
    else $error("upper bound hold missing");
  a_hold_lower: assert property (en && $signed(sweep_pos) <= $signed(lower) |=> hold_low)
    else $error("lower bound hold missing");
  a_burst_start: assert property (burst_arm |=> sweep_run && s.done_cnt == 13'h0000)
    else $error("burst did not start");
  a_burst_end: assert property (s.burst == sweep_trig_pkg::BURST_RUN && en && step
      && s.done_cnt + 13'h0001 == burst_len |=> !sweep_run [*2])
    else $error("burst ran past its count");
  a_seg0_manual: assert property (man |=> !seg0_clear)
    else $error("segment clear in manual mode");
  a_trig_always: assert property (en && code_a == `TRG_ALWAYS |=> trig_a)
    else $error("always trigger missing");
  a_trig_b_dir: assert property (en && code_b == `TRG_DIR_FALL && fall[0] |=> trig_b)
    else $error("trigger b falling edge missed");
  a_step_reserved: assert property (step_src == 2'h3 |=> !burst_step)
    else $error("burst advanced on reserved source");
  a_sync_latency: assert property (clk_rise_a |=> trig_a)
    else $error("synchronised edge not seen");
  a_reserved_code: assert property (code_a == 4'h3 |=> !trig_a)
    else $error("reserved trigger code fired");

endmodule

// [logic/sweep_trig_cfg.svh]
`ifndef SWEEP_TRIG_CFG_SVH
`define SWEEP_TRIG_CFG_SVH

// ************************************************
// register indices (byte address = index * 4)
// ************************************************
`define IDX_RECAL_CTRL   7'h4e
`define IDX_LIMIT_UPPER  7'h4f
`define IDX_LIMIT_LOWER  7'h50
`define IDX_UB_MSB       7'h51
`define IDX_UB_MID       7'h52
`define IDX_UB_LOW       7'h53
`define IDX_LB_MSB       7'h54
`define IDX_LB_MID       7'h55
`define IDX_LB_LOW       7'h56
`define IDX_BURST        7'h60
`define IDX_TRIGGER      7'h61
`define IDX_SWEEP_CTRL   7'h70
`define IDX_SWEEP_STAT   7'h71

// ************************************************
// field positions
// ************************************************
`define RC_LIMIT_MSB     11
`define RC_FAST_REUSE    9
`define RC_CAP_LO        1
`define BU_ENABLE        15
`define BU_COUNT_LO      2
`define TR_SEG0_CLEAR    15
`define TR_B_LO          7
`define TR_A_LO          3
`define TR_STEP_LO       0
`define CT_SWEEP_EN      0
`define CT_MANUAL        1
`define CT_CAP_USE       2

// ************************************************
// masks, fixed bits, reset values, limits
// ************************************************
`define MASK_RECAL_CTRL  16'h0bfe
`define MASK_FULL        16'hffff
`define MASK_BIT0        16'h0001
`define MASK_BURST       16'hfffc
`define MASK_TRIGGER     16'h87fb
`define MASK_CTRL        16'h0007
`define ONES_RECAL_CTRL  16'h0001
`define ONES_TRIGGER     16'h0800
`define REG_RESET        16'h0000
`define CAPCODE_MAX      8'hb7

// ************************************************
// trigger source and step source codes
// ************************************************
`define TRG_OFF          4'h0
`define TRG_CLK_RISE     4'h1
`define TRG_DIR_RISE     4'h2
`define TRG_ALWAYS       4'h4
`define TRG_CLK_FALL     4'h9
`define TRG_DIR_FALL     4'ha
`define STEP_TRANSITION  2'h0
`define STEP_TRIG_A      2'h1
`define STEP_TRIG_B      2'h2

`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// [logic/sweep_trig_pkg.sv]
package sweep_trig_pkg;

  typedef struct packed {
    logic        awvalid;
    logic [11:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [11:0] araddr;
    logic        rready;
  } axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_s;

  typedef struct packed {
    logic [2:0] core;
    logic [7:0] capcode;
    logic [8:0] bias;
  } seed_s;

  typedef enum logic [1:0] {BURST_IDLE, BURST_RUN, BURST_DONE} burst_e;

endpackage

// [dv/sweep_engine_model.sv]
`timescale 1ns/1ps
// ****************************************
// far side: sweep engine and calibrator
// ****************************************
module sweep_engine_model #(
  parameter sweep_trig_pkg::seed_s SEED = 20'h5a3c1
) (
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  reset_n,
  // from the block
  input  wire logic                  sweep_run,
  input  wire logic                  recal_req,
  input  wire logic                  step_go,
  input  wire logic [3:0]            step_gap,
  // to the block
  output logic                       sweep_step,
  output logic                       cal_done,
  output sweep_trig_pkg::seed_s      last_seed
);
  logic [3:0] gap_cnt;
  logic [1:0] cal_cnt;
  logic       req_d;

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      gap_cnt <= 4'h0;
      cal_cnt <= 2'h0;
      req_d <= 1'b0;
      sweep_step <= 1'b0;
      cal_done <= 1'b0;
      last_seed <= ~SEED;
    end else begin
      sweep_step <= 1'b0;
      cal_done <= 1'b0;
      req_d <= recal_req;
      gap_cnt <= (sweep_run && step_go) ? gap_cnt + 4'h1 : 4'h0;
      if (sweep_run && step_go && gap_cnt >= step_gap - 4'h1) begin
        sweep_step <= 1'b1;
        gap_cnt <= 4'h0;
      end
      // seed only valid with cal_done, so it churns otherwise
      last_seed <= ~last_seed;
      if (recal_req && !req_d) begin
        cal_cnt <= 2'h3;
      end else if (cal_cnt != 2'h0) begin
        cal_cnt <= cal_cnt - 2'h1;
      end
      if (cal_cnt == 2'h1) begin
        cal_done <= 1'b1;
        last_seed <= SEED;
      end
    end
  end
endmodule

// [dv/testbench.sv]
`timescale 1ns/1ps
`include "sweep_trig_cfg.svh"
module testbench;
  localparam sweep_trig_pkg::seed_s SEED = 20'h5a3c1;
  logic                     mclk = 1'b0;
  logic                     reset_n = 1'b0;
  sweep_trig_pkg::axi_req_s req = '0;
  sweep_trig_pkg::axi_rsp_s rsp;
  logic                     clk_pin = 1'b0;
  logic                     dir_pin = 1'b0;
  logic [32:0]              sweep_pos = '0;
  logic [32:0]              freq_move = '0;
  logic                     step_go = 1'b0;
  logic [3:0]               step_gap = 4'h4;
  logic                     sweep_step;
  logic                     cal_done;
  sweep_trig_pkg::seed_s    last_seed;
  sweep_trig_pkg::seed_s    seed;
  logic                     sweep_run;
  logic                     manual_mode;
  logic                     trig_a;
  logic                     trig_b;
  logic                     burst_step;
  logic                     seg0_clear;
  logic                     hold_high;
  logic                     hold_low;
  logic                     recal_req;
  logic                     seed_from_last;
  logic                     win = 1'b0;
  logic                     clr = 1'b0;
  int                       cnt_a = 0;
  int                       cnt_b = 0;
  int                       cnt_bs = 0;
  int                       cnt_s0 = 0;
  int                       error_cnt = 0;
  int                       checks_done = 0;
  logic [31:0]              rs = 32'h7b25;
  logic [33:0]              exp_q[$];
  logic [6:0]               ridx[12] = '{`IDX_RECAL_CTRL, `IDX_LIMIT_UPPER, `IDX_LIMIT_LOWER,
    `IDX_UB_MSB, `IDX_UB_MID, `IDX_UB_LOW, `IDX_LB_MSB, `IDX_LB_MID, `IDX_LB_LOW,
    `IDX_BURST, `IDX_TRIGGER, `IDX_SWEEP_CTRL};
  logic [15:0]              rmask[12] = '{`MASK_RECAL_CTRL, `MASK_FULL, `MASK_FULL,
    `MASK_BIT0, `MASK_FULL, `MASK_FULL, `MASK_BIT0, `MASK_FULL, `MASK_FULL,
    `MASK_BURST, `MASK_TRIGGER, `MASK_CTRL};
  logic [3:0]               tcode[10] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h9, 4'ha, 4'h3, 4'h5,
    4'hf, 4'h4};
  logic [32:0]              bpos[5] = '{33'h0_0000_0fff, 33'h0_0000_1000, 33'h1_ffff_f000,
    33'h1_ffff_f001, 33'h0_0000_2000};
  logic [1:0]               bexp[5] = '{2'h0, 2'h2, 2'h1, 2'h0, 2'h0};
  logic [32:0]              rmv[4] = '{33'h100, 33'h101, 33'h1_0000_0100, 33'h1_0000_0101};
  logic [1:0]               bsrc[5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
  logic [12:0]              bcnt[5] = '{13'h3, 13'h2, 13'h5, 13'h3, 13'h0};

  always #50 mclk = ~mclk;

  sweep_trigger_ctrl u_sweep_trigger_ctrl (
    .mclk(mclk), .reset_n(reset_n), .axi_req(req), .axi_rsp(rsp),
    .sweep_clock_pin(clk_pin), .sweep_direction_pin(dir_pin), .sweep_step(sweep_step),
    .sweep_pos(sweep_pos), .freq_move(freq_move), .cal_done(cal_done),
    .last_seed(last_seed), .sweep_run(sweep_run), .manual_mode(manual_mode),
    .trig_a(trig_a), .trig_b(trig_b), .burst_step(burst_step), .seg0_clear(seg0_clear),
    .hold_high(hold_high), .hold_low(hold_low), .recal_req(recal_req), .seed(seed),
    .seed_from_last(seed_from_last));

  sweep_engine_model #(.SEED(SEED)) u_sweep_engine_model (
    .mclk(mclk), .reset_n(reset_n), .sweep_run(sweep_run), .recal_req(recal_req),
    .step_go(step_go), .step_gap(step_gap), .sweep_step(sweep_step),
    .cal_done(cal_done), .last_seed(last_seed));

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [6:0] idx, input logic [15:0] d, input logic [1:0] er);
    logic [31:0] r;
    r = rnd();
    @(posedge mclk);
    req.awvalid <= 1'b1;
    req.awaddr <= {3'h0, idx, 2'h0};
    req.wvalid <= 1'b1;
    req.wdata <= {r[31:16], d};
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
      if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    req.bready <= 1'b0;
    chk({32'h0, rsp.bresp}, {32'h0, er});
  endtask

  task automatic rd(input logic [6:0] idx, input logic [33:0] exp);
    @(posedge mclk);
    exp_q.push_back(exp);
    req.arvalid <= 1'b1;
    req.araddr <= {3'h0, idx, 2'h0};
    req.rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    req.rready <= 1'b0;
  endtask

  task automatic open_win();
    @(posedge mclk);
    clr <= 1'b1;
    @(posedge mclk);
    clr <= 1'b0;
    win <= 1'b1;
  endtask

  task automatic close_win(input int n);
    repeat (n) @(posedge mclk);
    win <= 1'b0;
    @(posedge mclk);
  endtask

  // ****************************************
  // result watchers
  // ****************************************
  always @(posedge mclk) begin
    if (rsp.rvalid === 1'b1 && req.rready === 1'b1) begin
      if (exp_q.size() == 0) begin
        error_cnt++;
        $display("[ERR] %0t read data without a pending read", $time);
      end else begin
        chk({rsp.rresp, rsp.rdata}, exp_q.pop_front());
      end
    end
  end

  always @(posedge mclk) begin
    if (clr) begin
      cnt_a <= 0;
      cnt_b <= 0;
      cnt_bs <= 0;
      cnt_s0 <= 0;
    end else if (win) begin
      cnt_a <= cnt_a + int'(trig_a === 1'b1);
      cnt_b <= cnt_b + int'(trig_b === 1'b1);
      cnt_bs <= cnt_bs + int'(burst_step === 1'b1);
      cnt_s0 <= cnt_s0 + int'(seg0_clear === 1'b1);
    end
  end

  initial begin
    repeat (30000) @(posedge mclk);
    error_cnt++;
    print_verdict();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [31:0] d;
    logic [3:0]  c;
    int          e;
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    rd(`IDX_RECAL_CTRL, {`RESP_OKAY, 16'h0, `ONES_RECAL_CTRL});
    rd(`IDX_TRIGGER, {`RESP_OKAY, 16'h0, `ONES_TRIGGER});
    rd(`IDX_BURST, {`RESP_OKAY, 32'h0});
    for (int i = 0; i < 12; i++) begin
      d = rnd();
      if (i == 0) d[8] = 1'b0;
      if (i == 10) d[15] = 1'b0;
      wr(ridx[i], d[15:0], `RESP_OKAY);
      e = (i == 0) ? `ONES_RECAL_CTRL : (i == 10) ? `ONES_TRIGGER : 0;
      rd(ridx[i], {`RESP_OKAY, 16'h0, d[15:0] & rmask[i] | 16'(e)});
    end
    wr(`IDX_SWEEP_STAT, 16'hffff, `RESP_OKAY);
    wr(7'h7f, 16'h1234, `RESP_SLVERR);
    rd(7'h7f, {`RESP_SLVERR, 32'h0});
    wr(`IDX_BURST, 16'h0, `RESP_OKAY);
    for (int i = 0; i < 10; i++) begin
      c = tcode[i];
      wr(`IDX_TRIGGER, {5'h0, c, c, 3'h0}, `RESP_OKAY);
      wr(`IDX_SWEEP_CTRL, {15'h0, i < 9}, `RESP_OKAY);
      open_win();
      for (int k = 0; k < 20; k++) begin
        if (k == 0) clk_pin <= 1'b1;
        if (k == 4) clk_pin <= 1'b0;
        if (k == 8) dir_pin <= 1'b1;
        if (k == 12) dir_pin <= 1'b0;
        @(posedge mclk);
      end
      close_win(0);
      e = (i == 9) ? 0 : (c == 4'h4) ? 20 : (c inside {4'h1, 4'h2, 4'h9, 4'ha}) ? 1 : 0;
      chk(34'(cnt_a), 34'(e));
      chk(34'(cnt_b), 34'(e));
    end
    wr(`IDX_UB_MSB, 16'h0, `RESP_OKAY);
    wr(`IDX_UB_MID, 16'h0, `RESP_OKAY);
    wr(`IDX_UB_LOW, 16'h1000, `RESP_OKAY);
    wr(`IDX_LB_MSB, 16'h1, `RESP_OKAY);
    wr(`IDX_LB_MID, 16'hffff, `RESP_OKAY);
    wr(`IDX_LB_LOW, 16'hf000, `RESP_OKAY);
    for (int i = 0; i < 5; i++) begin
      wr(`IDX_SWEEP_CTRL, {15'h0, i < 4}, `RESP_OKAY);
      sweep_pos <= bpos[i];
      repeat (3) @(posedge mclk);
      chk({32'h0, hold_high, hold_low}, {32'h0, bexp[i]});
    end
    sweep_pos <= '0;
    wr(`IDX_LIMIT_UPPER, 16'h0, `RESP_OKAY);
    wr(`IDX_LIMIT_LOWER, 16'h0100, `RESP_OKAY);
    wr(`IDX_SWEEP_CTRL, 16'h0001, `RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      wr(`IDX_RECAL_CTRL, (i < 2) ? 16'h0 : 16'h0800, `RESP_OKAY);
      freq_move <= rmv[i];
      repeat (3) @(posedge mclk);
      chk({33'h0, recal_req}, {33'h0, i[0]});
    end
    freq_move <= '0;
    wr(`IDX_RECAL_CTRL, 16'h0200, `RESP_OKAY);
    repeat (2) @(posedge mclk);
    chk({13'h0, seed_from_last, seed}, {13'h0, 1'b1, SEED});
    for (int i = 0; i < 2; i++) begin
      wr(`IDX_RECAL_CTRL, {7'h0, (i == 0) ? `CAPCODE_MAX : 8'h50, 1'b0}, `RESP_OKAY);
      wr(`IDX_SWEEP_CTRL, 16'h0005, `RESP_OKAY);
      repeat (2) @(posedge mclk);
      chk({26'h0, seed.capcode}, {26'h0, (i == 0) ? `CAPCODE_MAX : 8'h50});
    end
    wr(`IDX_TRIGGER, 16'h8000, `RESP_OKAY);
    for (int i = 0; i < 2; i++) begin
      wr(`IDX_SWEEP_CTRL, {14'h0, i[0], 1'b0}, `RESP_OKAY);
      open_win();
      wr(`IDX_SWEEP_CTRL, {14'h0, i[0], 1'b1}, `RESP_OKAY);
      close_win(6);
      chk(34'(cnt_s0), 34'(i == 0));
      chk({33'h0, manual_mode}, {33'h0, i[0]});
    end
    step_go <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      wr(`IDX_SWEEP_CTRL, 16'h0, `RESP_OKAY);
      wr(`IDX_TRIGGER, {5'h0, 4'h4, 4'h4, 1'b0, bsrc[i]}, `RESP_OKAY);
      wr(`IDX_BURST, {1'b1, bcnt[i], 2'h0}, `RESP_OKAY);
      step_gap <= i[0] ? 4'h6 : 4'h1;
      open_win();
      wr(`IDX_SWEEP_CTRL, 16'h0001, `RESP_OKAY);
      close_win(60);
      e = (bsrc[i] == 2'h3) ? 0 : int'(bcnt[i]);
      chk(34'(cnt_bs), 34'(e));
      chk({33'h0, sweep_run}, {33'h0, bsrc[i] == 2'h3});
      d = (bsrc[i] == 2'h3) ? 32'h2000 : {19'h2, bcnt[i]};
      rd(`IDX_SWEEP_STAT, {`RESP_OKAY, d});
    end
    @(posedge mclk);
    print_verdict();
  end
endmodule
